// [cbd_boot_autodetect.sv]
// Purpose: CAN boot link setup: bit rate measurement, timing derivation,
//          one acknowledge frame, then intake of loader bytes to memory.
// Assumes: Receive line and frame ports synchronous to sys_clk.
// Notes:   Registers on APB; zero wait states.
`timescale 1ns/1ps
`default_nettype none

module cbd_boot_autodetect #(
  // Arbitrary neutral value
  parameter logic [15:0] CHIP_ID = 16'h1234
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rstn,
  // APB slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // CAN line and transmit pin
  input  wire logic                   can_receive_line,
  output logic                        transmit_pin_latch,
  output logic                        transmit_pin_oe,
  // Bit timing to the CAN controller
  output cbd_pkg::cbd_btr_t           btr_value,
  output logic                        btr_load,
  output logic                        rx_enable,
  // Acknowledge object
  output cbd_pkg::cbd_ack_frame_t     ack_frame,
  output logic                        ack_valid,
  input  wire logic                   ack_ready,
  // Loader receive object
  input  wire cbd_pkg::cbd_rx_frame_t rx_frame,
  input  wire logic                   rx_valid,
  output logic                        rx_ready,
  // Memory write port
  output cbd_pkg::cbd_load_t          mem_word,
  output logic                        mem_valid,
  input  wire logic                   mem_ready
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  cbd_pkg::cbd_state_t state_r;
  cbd_pkg::cbd_state_t state_nxt;
  cbd_pkg::cbd_btr_t   btr_r;
  cbd_pkg::cbd_status_t status_w;
  cbd_pkg::cbd_load_t  push_word;
  logic        rx_q_r;
  logic [15:0] cnt_r;
  logic        ovf_r;
  logic [2:0]  rises_r;
  logic [5:0]  presc_r;
  logic [4:0]  qpb_r;
  logic        invalid_r;
  logic        enable_r;
  logic        restart_r;
  logic        tx_oe_r;
  logic        btr_load_r;
  logic [7:0]  pushed_r;
  logic [7:0]  drained_r;
  logic [31:0] prdata_r;
  wire  logic  rise;
  wire  logic  fall;
  wire  logic  last_rise;
  wire  logic  [31:0] cnt32;
  wire  logic  [31:0] presc_q;
  wire  logic  [31:0] presc1;
  wire  logic  [31:0] lo_lim;
  wire  logic  [31:0] hi_lim;
  wire  logic  [31:0] seg_div;
  wire  logic  [31:0] qpb_q;
  wire  logic  [31:0] qpb_rem;
  wire  logic         round_up;
  wire  logic  [31:0] qpb32;
  wire  logic         range_ok;
  wire  logic         qpb_ok;
  wire  logic  [5:0]  qpb6;
  wire  logic  [5:0]  t2_pct;
  wire  logic  [5:0]  t2_fit;
  wire  logic  [5:0]  seg_two;
  wire  logic  [5:0]  seg_one;
  wire  logic         rx_take;
  wire  logic         id_match;
  wire  logic         buf_in_ready;
  wire  logic         mem_take;
  wire  logic         load_done;
  wire  logic         apb_setup;
  wire  logic         apb_wr;
  wire  logic         hit_ctrl;
  wire  logic         hit_status;
  wire  logic         hit_meas;
  wire  logic         hit_timing;
  wire  logic         hit_any;
  wire  logic  [31:0] rd_mux;

  ////////////////////////////////////////////////////////////////////////////
  // Line edges and measurement
  assign rise      = can_receive_line & ~rx_q_r;
  assign fall      = ~can_receive_line & rx_q_r;
  assign last_rise = rise && (rises_r == cbd_pkg::MEAS_LAST_RISE);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rx_q_r <= 1'b1;
    end else begin
      rx_q_r <= can_receive_line;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r   <= '0;
      ovf_r   <= 1'b0;
      rises_r <= '0;
    end else if (state_r == cbd_pkg::ST_WAIT) begin
      cnt_r   <= '0;
      ovf_r   <= 1'b0;
      rises_r <= '0;
    end else if (state_r == cbd_pkg::ST_MEAS) begin
      if (cnt_r == cbd_pkg::MEAS_MAX) begin
        ovf_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 16'h0001;
      end
      if (rise) begin
        rises_r <= rises_r + 3'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timing derivation
  assign cnt32    = {16'h0000, cnt_r};
  assign presc_q  = cnt32 / cbd_pkg::PRESC_DIVISOR;
  assign presc1   = {26'h0, presc_r} + 32'h1;
  assign lo_lim   = cbd_pkg::RANGE_LO_MUL * presc1;
  assign hi_lim   = cbd_pkg::RANGE_HI_MUL * presc1;
  assign range_ok = (cnt32 >= lo_lim) && (cnt32 <= hi_lim);
  assign seg_div  = cbd_pkg::SEG_UNIT * presc1;
  assign qpb_q    = cnt32 / seg_div;
  assign qpb_rem  = cnt32 % seg_div;
  assign round_up = {qpb_rem[30:0], 1'b0} > seg_div;
  assign qpb32    = qpb_q + {31'h0, round_up};
  assign qpb_ok   = (qpb32 >= cbd_pkg::QPB_MIN) &&
                    (qpb32 <= cbd_pkg::QPB_MAX);

  assign qpb6   = {1'b0, qpb_r};
  assign t2_pct = (qpb6 + cbd_pkg::SP_STEP - 6'h01) / cbd_pkg::SP_STEP;
  assign t2_fit  = (qpb6 > cbd_pkg::SEG_ONE_MAX + 6'h01) ?
                   qpb6 - cbd_pkg::SEG_ONE_MAX - 6'h01 : 6'h00;
  assign seg_two = (t2_fit > t2_pct) ? t2_fit : t2_pct;
  assign seg_one = qpb6 - 6'h01 - seg_two;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      presc_r <= '0;
      qpb_r   <= '0;
    end else begin
      if (state_r == cbd_pkg::ST_CPRE) begin
        presc_r <= presc_q[5:0];
      end
      if (state_r == cbd_pkg::ST_CSEG) begin
        qpb_r <= qpb32[4:0];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      btr_r      <= '0;
      btr_load_r <= 1'b0;
    end else begin
      btr_load_r <= (state_r == cbd_pkg::ST_PROG);
      if (state_r == cbd_pkg::ST_PROG) begin
        btr_r.zero     <= 1'b0;
        btr_r.phase_segment_two_m1 <= 3'(seg_two - 6'h01);
        btr_r.phase_segment_one_m1 <= 4'(seg_one - 6'h01);
        btr_r.sjw_m1               <= cbd_pkg::SJW_QUANTA - 2'h1;
        btr_r.bit_rate_prescaler   <= presc_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence control
  assign load_done = (drained_r == cbd_pkg::LOAD_BYTES);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      cbd_pkg::ST_IDLE: begin
        if (enable_r && can_receive_line) begin
          state_nxt = cbd_pkg::ST_WAIT;
        end
      end
      cbd_pkg::ST_WAIT: begin
        if (fall) begin
          state_nxt = cbd_pkg::ST_MEAS;
        end
      end
      cbd_pkg::ST_MEAS: begin
        if (ovf_r) begin
          state_nxt = cbd_pkg::ST_FAIL;
        end else if (last_rise) begin
          state_nxt = cbd_pkg::ST_CPRE;
        end
      end
      cbd_pkg::ST_CPRE: begin
        if (presc_q >= cbd_pkg::PRESC_LIMIT) begin
          state_nxt = cbd_pkg::ST_FAIL;
        end else begin
          state_nxt = cbd_pkg::ST_CSEG;
        end
      end
      cbd_pkg::ST_CSEG: begin
        if (range_ok && qpb_ok) begin
          state_nxt = cbd_pkg::ST_PROG;
        end else begin
          state_nxt = cbd_pkg::ST_FAIL;
        end
      end
      cbd_pkg::ST_PROG: begin
        state_nxt = cbd_pkg::ST_ACK;
      end
      cbd_pkg::ST_ACK: begin
        if (ack_ready) begin
          state_nxt = cbd_pkg::ST_LOAD;
        end
      end
      cbd_pkg::ST_LOAD: begin
        if (load_done) begin
          state_nxt = cbd_pkg::ST_DONE;
        end
      end
      cbd_pkg::ST_DONE,
      cbd_pkg::ST_FAIL: begin
        if (restart_r) begin
          state_nxt = cbd_pkg::ST_IDLE;
        end
      end
      default: begin
        state_nxt = cbd_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= cbd_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      invalid_r <= 1'b0;
    end else if (state_nxt == cbd_pkg::ST_FAIL) begin
      invalid_r <= 1'b1;
    end else if (state_r == cbd_pkg::ST_WAIT) begin
      invalid_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_oe_r <= 1'b0;
    end else if (state_r == cbd_pkg::ST_PROG) begin
      tx_oe_r <= 1'b1;
    end
  end

  assign transmit_pin_latch = 1'b1;
  assign transmit_pin_oe    = tx_oe_r;
  assign btr_value          = btr_r;
  assign btr_load           = btr_load_r;

  ////////////////////////////////////////////////////////////////////////////
  // Acknowledge frame
  // identifier, length, payload
  assign ack_frame.id   = cbd_pkg::ACK_ID;
  assign ack_frame.dlc  = cbd_pkg::ACK_DLC;
  assign ack_frame.data = {cbd_pkg::ACK_BYTE0, CHIP_ID};
  assign ack_valid      = (state_r == cbd_pkg::ST_ACK);

  ////////////////////////////////////////////////////////////////////////////
  // Loader intake
  assign rx_enable = (state_r == cbd_pkg::ST_LOAD);
  assign rx_ready  = rx_enable && buf_in_ready &&
                     (pushed_r != cbd_pkg::LOAD_BYTES);
  assign rx_take   = rx_valid && rx_ready;
  assign id_match  = (rx_frame.id == cbd_pkg::LOAD_ID);
  assign push_word.addr = cbd_pkg::LOAD_BASE + {16'h0000, pushed_r};
  assign push_word.data = rx_frame.data0;
  assign mem_take       = mem_valid && mem_ready;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pushed_r  <= '0;
      drained_r <= '0;
    end else if (state_r == cbd_pkg::ST_WAIT) begin
      pushed_r  <= '0;
      drained_r <= '0;
    end else begin
      if (rx_take && id_match) begin
        pushed_r <= pushed_r + 8'h01;
      end
      if (mem_take) begin
        drained_r <= drained_r + 8'h01;
      end
    end
  end

  cbd_pair_buf #(
    .WIDTH (32),
    .DEPTH (cbd_pkg::BUF_DEPTH)
  ) u_buf (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .in_valid  (rx_take && id_match),
    .in_ready  (buf_in_ready),
    .in_data   (push_word),
    .out_valid (mem_valid),
    .out_ready (mem_ready),
    .out_data  (mem_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB registers
  assign apb_setup  = psel && !penable;
  assign apb_wr     = psel && penable && pwrite;
  assign hit_ctrl   = (paddr == cbd_pkg::ADDR_CTRL);
  assign hit_status = (paddr == cbd_pkg::ADDR_STATUS);
  assign hit_meas   = (paddr == cbd_pkg::ADDR_MEASURE);
  assign hit_timing = (paddr == cbd_pkg::ADDR_TIMING);
  assign hit_any    = hit_ctrl | hit_status | hit_meas | hit_timing;

  assign status_w.rsv     = '0;
  assign status_w.loaded  = drained_r;
  assign status_w.done    = (state_r == cbd_pkg::ST_DONE);
  assign status_w.invalid = invalid_r;
  assign status_w.state   = state_r;

  assign rd_mux = hit_ctrl   ? {31'h0, enable_r} :
                  hit_status ? status_w :
                  hit_meas   ? cnt32 :
                  hit_timing ? {16'h0000, btr_r} : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= '0;
    end else if (apb_setup) begin
      prdata_r <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      enable_r  <= cbd_pkg::CTRL_ENABLE_RST;
      restart_r <= 1'b0;
    end else begin
      restart_r <= apb_wr && hit_ctrl &&
                   pwdata[cbd_pkg::CTRL_RESTART_BIT];
      if (apb_wr && hit_ctrl) begin
        enable_r <= pwdata[cbd_pkg::CTRL_ENABLE_BIT];
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

endmodule

`default_nettype wire

// [cbd_pkg.sv]
// Purpose: Shared constants and types for the CAN boot bit rate autodetect.
// Assumes: 20 MHz system clock, APB register access.
// Notes:   Bit timing layout matches the CAN controller timing word.
`default_nettype none

package cbd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_MEASURE = 12'h008;
  localparam logic [11:0] ADDR_TIMING  = 12'h00C;

  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam logic        CTRL_ENABLE_RST  = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Measurement and derivation
  localparam logic [15:0] MEAS_MAX       = 16'hFFFF;
  localparam logic [2:0]  MEAS_LAST_RISE = 3'h4;
  localparam logic [31:0] PRESC_DIVISOR  = 32'h0000_05AB;
  localparam logic [31:0] SEG_UNIT       = 32'h0000_003A;
  localparam logic [31:0] RANGE_LO_MUL   = 32'h0000_01D0;
  localparam logic [31:0] RANGE_HI_MUL   = 32'h0000_05AA;
  localparam logic [31:0] PRESC_LIMIT    = 32'h0000_0040;
  localparam logic [31:0] QPB_MIN        = 32'h0000_0008;
  localparam logic [31:0] QPB_MAX        = 32'h0000_0019;
  localparam logic [5:0]  SP_STEP        = 6'h05;
  localparam logic [5:0]  SEG_ONE_MAX    = 6'h10;
  localparam logic [1:0]  SJW_QUANTA     = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Frames and loading
  localparam logic [10:0] ACK_ID      = 11'h0E6;
  localparam logic [3:0]  ACK_DLC     = 4'h3;
  localparam logic [7:0]  ACK_BYTE0   = 8'hD5;
  localparam logic [10:0] LOAD_ID     = 11'h005;
  localparam logic [7:0]  LOAD_BYTES  = 8'h80;
  localparam logic [23:0] LOAD_BASE   = 24'h00FA40;
  localparam int unsigned BUF_DEPTH   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic       zero;
    logic [2:0] phase_segment_two_m1;
    logic [3:0] phase_segment_one_m1;
    logic [1:0] sjw_m1;
    logic [5:0] bit_rate_prescaler;
  } cbd_btr_t;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [23:0] data;
  } cbd_ack_frame_t;

  typedef struct packed {
    logic [10:0] id;
    logic [3:0]  dlc;
    logic [7:0]  data0;
  } cbd_rx_frame_t;

  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  data;
  } cbd_load_t;

  typedef struct packed {
    logic [17:0] rsv;
    logic [7:0]  loaded;
    logic        done;
    logic        invalid;
    logic [3:0]  state;
  } cbd_status_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'h0,
    ST_WAIT  = 4'h1,
    ST_MEAS  = 4'h3,
    ST_CPRE  = 4'h2,
    ST_CSEG  = 4'h6,
    ST_PROG  = 4'h7,
    ST_ACK   = 4'h5,
    ST_LOAD  = 4'h4,
    ST_DONE  = 4'hC,
    ST_FAIL  = 4'hD
  } cbd_state_t;

endpackage

`default_nettype wire

// [cbd_pair_buf.sv]
// Purpose: Small valid/ready FIFO between loader intake and memory writes.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Depth two lets a drain stall cost no incoming word.
`timescale 1ns/1ps
`default_nettype none

module cbd_pair_buf #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 2
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rstn,
  // Filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wptr_r;
  logic [PW-1:0]    rptr_r;
  logic [PW:0]      fill_r;
  wire  logic       push;
  wire  logic       pop;

  assign in_ready  = (fill_r != (PW+1)'(DEPTH));
  assign out_valid = (fill_r != '0);
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_r[rptr_r];

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wptr_r <= '0;
      rptr_r <= '0;
      fill_r <= '0;
    end else begin
      if (push) begin
        wptr_r <= (wptr_r == PW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= (rptr_r == PW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
      end
      fill_r <= fill_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_ent
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          mem_r[gi] <= '0;
        end else if (push && wptr_r == PW'(gi)) begin
          mem_r[gi] <= in_data;
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// [cbd_pkg_unused_guard.sv]
`default_nettype none
`default_nettype wire

// [cbd_boot_properties.sv]
// Purpose: Port-level checks for the CAN boot autodetect block.
// Assumes: One clock, asynchronous active-low reset.
// Notes:   Bound to the top module below.
`timescale 1ns/1ps
`default_nettype none

module cbd_boot_checker (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   rstn,
  // Pin and timing
  input wire logic                   transmit_pin_latch,
  input wire logic                   transmit_pin_oe,
  input wire cbd_pkg::cbd_btr_t      btr_value,
  input wire logic                   btr_load,
  input wire logic                   rx_enable,
  // Frames and memory
  input wire cbd_pkg::cbd_ack_frame_t ack_frame,
  input wire logic                   ack_valid,
  input wire logic                   ack_ready,
  input wire logic                   rx_ready,
  input wire cbd_pkg::cbd_load_t     mem_word,
  input wire logic                   mem_valid,
  input wire logic                   mem_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  logic ack_seen_r;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) ack_seen_r <= 1'b0;
    else if (btr_load) ack_seen_r <= 1'b0;
    else if (ack_valid && ack_ready) ack_seen_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////
  a_latch_recessive: assert property (transmit_pin_latch == 1'b1)
    else $error("transmit latch not recessive");
  a_oe_sticky: assert property (transmit_pin_oe |=> transmit_pin_oe)
    else $error("transmit enable dropped");
  a_load_before_rx: assert property (
    btr_load |-> transmit_pin_oe && !rx_enable)
    else $error("timing load out of order");
  a_jump_two: assert property (btr_load |-> btr_value.sjw_m1 == 2'h1)
    else $error("jump width not two");
  a_bit_span: assert property (
    btr_load |-> (3 + btr_value.phase_segment_one_m1
    + btr_value.phase_segment_two_m1) inside {[8:25]})
    else $error("bit time out of range");
  a_sample_point: assert property (
    btr_load |-> 100 * (2 + btr_value.phase_segment_one_m1)
    <= 80 * (3 + btr_value.phase_segment_one_m1
    + btr_value.phase_segment_two_m1))
    else $error("sample point too late");
  a_timing_frozen: assert property (rx_enable |-> $stable(btr_value))
    else $error("timing changed during intake");
  a_ack_content: assert property (
    ack_valid |-> ack_frame.id == 11'h0E6 && ack_frame.dlc == 4'h3
    && ack_frame.data[23:16] == 8'hD5)
    else $error("acknowledge frame wrong");
  // A fresh timing load starts a new bootstrap and rearms the offer
  a_single_ack: assert property (
    ack_seen_r && !btr_load |-> !ack_valid)
    else $error("second acknowledge offered");
  a_store_window: assert property (
    mem_valid |-> mem_word.addr inside {[24'h00FA40:24'h00FABF]})
    else $error("store address out of window");
  a_word_holds: assert property (
    mem_valid && !mem_ready |=> mem_valid && $stable(mem_word))
    else $error("stalled word not held");
  a_intake_gate: assert property (rx_ready |-> rx_enable)
    else $error("intake ready outside loading");
endmodule

bind cbd_boot_autodetect cbd_boot_checker chk (.sys_clk, .rstn,
  .transmit_pin_latch, .transmit_pin_oe, .btr_value, .btr_load, .rx_enable,
  .ack_frame, .ack_valid, .ack_ready, .rx_ready, .mem_word, .mem_valid,
  .mem_ready);

`default_nettype wire

// [cbd_host_model.sv]
// Purpose: Host loader on the CAN side of the boot block.
// Assumes: Frame ports synchronous to sys_clk.
// Notes:   Line idles recessive (pull-up); released frame bits inverted.
`timescale 1ns/1ps
`default_nettype none

module cbd_host_model (
  // Clock
  input wire logic                sys_clk,
  // CAN line
  output logic                    can_receive_line,
  // Loader frames
  output cbd_pkg::cbd_rx_frame_t  rx_frame,
  output logic                    rx_valid,
  input wire logic                rx_ready,
  // Acknowledge intake
  input wire logic                ack_valid,
  output logic                    ack_ready
);
  initial begin
    can_receive_line = 1'b1;
    rx_frame = '0;
    rx_valid = 1'b0;
    ack_ready = 1'b0;
  end

  task automatic zero_frame(input int bit_cyc);
    int runs[14] = '{5, 1, 5, 1, 5, 1, 5, 1, 5, 1, 4, 1, 1, 11};
    @(posedge sys_clk);
    for (int k = 0; k < 14; k++) begin
      can_receive_line <= k[0];
      repeat (runs[k] * bit_cyc) @(posedge sys_clk);
    end
  endtask

  task automatic send_frame(input logic [10:0] id, input logic [3:0] dlc,
                            input logic [7:0] d);
    @(posedge sys_clk);
    rx_frame <= {id, dlc, d};
    rx_valid <= 1'b1;
    do @(posedge sys_clk); while (rx_ready !== 1'b1);
    rx_valid <= 1'b0;
    rx_frame <= ~{id, dlc, d};
  endtask

  task automatic take_ack();
    repeat (3) @(posedge sys_clk);
    ack_ready <= 1'b1;
    do @(posedge sys_clk); while (ack_valid !== 1'b1);
    ack_ready <= 1'b0;
  endtask
endmodule

`default_nettype wire

// [tb.sv]
// Purpose: Self-checking bench for the CAN boot autodetect block.
// Assumes: 20 MHz clock, APB register access.
// Notes:   Host model drives the CAN side; bench drains memory writes.
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr, perr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        can_receive_line, transmit_pin_latch, transmit_pin_oe;
  logic        btr_load, rx_enable, ack_valid, ack_ready, rx_valid;
  logic        rx_ready, mem_valid;
  logic        mem_ready = 1'b0;
  logic [3:0]  cyc = 4'h0;
  int          err_count, checked, n_mem;
  cbd_pkg::cbd_btr_t       btr_value;
  cbd_pkg::cbd_ack_frame_t ack_frame;
  cbd_pkg::cbd_rx_frame_t  rx_frame;
  cbd_pkg::cbd_load_t      mem_word;

  cbd_boot_autodetect #(.CHIP_ID(16'hA55A)) dut (.sys_clk, .rstn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .can_receive_line, .transmit_pin_latch, .transmit_pin_oe, .btr_value,
    .btr_load, .rx_enable, .ack_frame, .ack_valid, .ack_ready, .rx_frame,
    .rx_valid, .rx_ready, .mem_word, .mem_valid, .mem_ready);
  cbd_host_model host (.sys_clk, .can_receive_line, .rx_frame, .rx_valid,
    .rx_ready, .ack_valid, .ack_ready);

  initial sys_clk = 1'b0;
  always #25 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Memory side drains with stalls and checks each stored byte
  always @(posedge sys_clk) begin
    cyc <= cyc + 4'h1;
    mem_ready <= cyc[3];
    if (mem_valid && mem_ready) begin
      chk(mem_word, {24'h00FA40 + 24'(n_mem), 8'(n_mem) ^ 8'hA5}, "mem");
      n_mem++;
    end
  end

  initial begin
    #(50 * 40000);
    err_count++;
    $display("CHECK FAILED %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (16) @(posedge sys_clk);
    rstn <= 1'b1;
    apb(1'b0, cbd_pkg::ADDR_CTRL, 32'h0);
    chk(rd, 32'h1, "ctrl reset");
    apb(1'b0, 12'h010, 32'h0);
    chk({rd[30:0], perr}, 32'h1, "unmapped");
    host.zero_frame(20);
    for (int i = 0; i < 300 && ack_valid !== 1'b1; i++) @(posedge sys_clk);
    chk(32'(btr_value), 32'h1640, "timing word");
    chk({transmit_pin_oe, transmit_pin_latch}, 2'h3, "pin");
    chk({ack_frame.id, ack_frame.dlc, ack_frame.data[23:16]},
        {11'h0E6, 4'h3, 8'hD5}, "ack head");
    chk(ack_frame.data[15:0], 16'hA55A, "ack chip id");
    host.take_ack();
    apb(1'b0, cbd_pkg::ADDR_MEASURE, 32'h0);
    chk(32'(rd >= 579 && rd <= 581), 32'h1, "count");
    apb(1'b0, cbd_pkg::ADDR_TIMING, 32'h0);
    chk(rd, 32'h1640, "timing reg");
    for (int n = 0; n < 128; n++) begin
      if (n == 64) host.send_frame(11'h004, 4'h1, 8'hFF);
      if (n == 65) host.send_frame(11'h405, 4'h1, 8'hEE);
      host.send_frame(cbd_pkg::LOAD_ID, (n == 100) ? 4'h8 : 4'h1,
                      8'(n) ^ 8'hA5);
    end
    for (int i = 0; i < 500 && n_mem < 128; i++) @(posedge sys_clk);
    repeat (4) @(posedge sys_clk);
    chk(n_mem, 128, "byte count");
    chk(rx_ready, 1'b0, "intake closed");
    apb(1'b0, cbd_pkg::ADDR_STATUS, 32'h0);
    chk(rd[13:0], 14'h202C, "status done");
    apb(1'b1, cbd_pkg::ADDR_CTRL, 32'h3);
    repeat (8) @(posedge sys_clk);
    host.zero_frame(2);
    repeat (20) @(posedge sys_clk);
    apb(1'b0, cbd_pkg::ADDR_STATUS, 32'h0);
    chk(rd[5:0], 6'h1D, "short count fails");
    chk(32'(btr_value), 32'h1640, "timing kept");
    chk(ack_valid, 1'b0, "no second ack");
    // 19 cycles a bit: remainder is exactly half, so no rounding up
    apb(1'b1, cbd_pkg::ADDR_CTRL, 32'h3);
    repeat (8) @(posedge sys_clk);
    host.zero_frame(19);
    chk(32'(btr_value), 32'h1540, "half remainder truncated");
    apb(1'b0, cbd_pkg::ADDR_MEASURE, 32'h0);
    chk(rd, 32'h227, "exact count");
    summarize();
  end
endmodule

`default_nettype wire
